// [core/serial_adc_readout.sv]
// Purpose: conversion sequencing and three-wire serial readout
// Assumes: shift_clk only runs while the strobe is low; cmp_above is
//   the comparator answer for dac_trial from the analog core
// Notes: serial data is a mux of a stable word by a shift_clk counter
`timescale 1ns/10ps
`include "adc_defines.svh"
module serial_adc_readout #(
	parameter int SPEED_GRADE = `SPEED_GRADE_DEF
) (
	input wire logic mclk, // core clock, stands in for the oscillator
	input wire logic reset_n, // synchronous reset, active low
	input wire logic convert_strobe, // convert strobe pin, async
	input wire logic shift_clk, // host shift clock
	input wire logic cmp_above, // input at or above dac_trial
	output logic serial_result_out, // serial data
	output logic serial_result_oe, // high while the data pin is driven
	output logic track_hold, // high holds the sample, low tracks
	output logic bias_on, // bias currents enabled
	output logic [11:0] dac_trial, // successive-approximation trial code
	output logic convert_strobe_busy // conversion in progress
);
	localparam int TCONV_NS = (SPEED_GRADE == 0) ? `TCONV_G0_NS :
		(SPEED_GRADE == 1) ? `TCONV_G1_NS : `TCONV_G2_NS;
	localparam int STEP = `STEP_CYCLES(TCONV_NS);
	localparam int CONVERT_STROBE_LIMIT = `CONVERT_STROBE_CYCLES(TCONV_NS);
	// store shows 12 steps plus one edge after the rise, eight already held
	localparam int CONVERT_STROBE_LAG = `RESULT_BITS * STEP - 7;
	localparam logic [6:0] STEP_LOAD = 7'(STEP - 1);

	adc_pkg::core_state_t q;
	adc_pkg::core_state_t d;
	adc_pkg::link_state_t lq;
	adc_pkg::link_state_t ld;

	logic strobe_lvl;
	logic rise;
	logic fall;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [11:0] fifo_out_data;

	// bit n of the word as seen on the wire, zero once twelve are out
	function automatic logic wire_bit(input logic [11:0] w,
		input logic [3:0] n);
		logic b;
		b = 1'b0;
		if (n < `LINK_SAT) begin
			b = w[4'hB - n];
		end
		return b;
	endfunction

	pin_sync u_strobe_sync (
		.clk(mclk),
		.reset_n(reset_n),
		.pin_in(convert_strobe),
		.level(strobe_lvl)
	);

	// results queue here so a slow reader can stall the converter
	result_fifo #(
		.WIDTH(`RESULT_BITS),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.reset_n(reset_n),
		.in_valid(q.push),
		.in_ready(fifo_in_ready),
		.in_data(q.trial),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// strobe edges as seen after the synchroniser
	assign rise = strobe_lvl && !q.strobe_q;
	assign fall = !strobe_lvl && q.strobe_q;
	assign fifo_out_ready = fall && q.phase != adc_pkg::ST_TRACK;

	// conversion sequencer
	always_comb begin
		d = q;
		d.strobe_q = strobe_lvl;
		case (q.phase)
			adc_pkg::ST_TRACK: begin
				if (rise) begin
					d.phase = adc_pkg::ST_CONVERT; // R01 R09
					d.hold = 1'b1;
					d.drive_en = 1'b0; // R01 R12
					d.bias_on = 1'b1;
					d.bit_idx = 4'hB;
					d.trial = `MSB_TRIAL;
					d.timer = STEP_LOAD;
				end else if (!strobe_lvl) begin
					d.drive_en = 1'b1;
				end
			end
			adc_pkg::ST_CONVERT: begin
				// step time comes from mclk alone, shift_clk plays no part
				if (q.timer != 7'h00) begin
					d.timer = q.timer - 7'h01; // R09 R10
				end else begin
					if (!cmp_above) begin
						d.trial[q.bit_idx] = 1'b0;
					end
					if (q.bit_idx == 4'h0) begin
						d.phase = adc_pkg::ST_STORE;
						d.push = 1'b1;
					end else begin
						d.bit_idx = q.bit_idx - 4'h1;
						d.trial[q.bit_idx - 4'h1] = 1'b1;
						d.timer = STEP_LOAD;
					end
				end
			end
			adc_pkg::ST_STORE: begin
				// a full buffer stalls here, keeping the sample held
				if (fifo_in_ready) begin
					d.push = 1'b0;
					d.phase = adc_pkg::ST_SLEEP; // R02
					d.bias_on = 1'b0; // R02
				end
			end
			adc_pkg::ST_SLEEP: begin
				d.hold = 1'b1; // R06
				d.bias_on = 1'b0;
			end
			default: begin
				d.phase = adc_pkg::ST_TRACK;
			end
		endcase
		// strobe low wakes the part from any phase; a strobe dropped
		// mid-conversion abandons the result and keeps the older word
		if (fall && q.phase != adc_pkg::ST_TRACK) begin
			d.phase = adc_pkg::ST_TRACK;
			d.hold = 1'b0; // R07
			d.bias_on = 1'b1; // R07
			d.drive_en = 1'b1; // R03
			d.push = 1'b0;
			if (fifo_out_valid) begin
				d.word = fifo_out_data; // R03
			end
		end
		// registered so the busy output comes straight from a flop
		d.busy = (d.phase == adc_pkg::ST_CONVERT);
	end

	// core state register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			q <= '{phase: adc_pkg::ST_TRACK, strobe_q: 1'b0,
				timer: 7'h00, bit_idx: 4'h0, trial: 12'h000,
				word: 12'h000, drive_en: 1'b0, hold: 1'b0,
				bias_on: 1'b1, push: 1'b0, busy: 1'b0};
		end else begin
			q <= d;
		end
	end

	// link side: count falling shift clocks, saturate after twelve
	always_comb begin
		ld = lq;
		if (lq.shifted != `LINK_SAT) begin
			ld.shifted = lq.shifted + 4'h1; // R04
		end
	end

	// the strobe itself ends the frame, since shift_clk may be stopped
	always_ff @(negedge shift_clk or posedge convert_strobe) begin
		if (convert_strobe) begin
			lq <= '{shifted: 4'h0};
		end else begin
			lq <= ld;
		end
	end

	// word stays still while the strobe is low, so the mux crossing is safe;
	// count zero shows result_msb before any shift clock edge
	assign serial_result_out = wire_bit(q.word, lq.shifted); // R03 R05
	assign serial_result_oe = q.drive_en; // R12
	assign track_hold = q.hold; // R06
	assign bias_on = q.bias_on;
	assign dac_trial = q.trial;
	assign convert_strobe_busy = q.busy;

	// checks, core domain
	logic [10:0] convert_strobe_age_q;
	// word a wake should load: the popped result, else the older word
	logic [11:0] wake_word;

	assign wake_word = fifo_out_valid ? fifo_out_data : q.word;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			convert_strobe_age_q <= 11'h000;
		end else if (q.phase == adc_pkg::ST_CONVERT) begin
			convert_strobe_age_q <= convert_strobe_age_q + 11'h001;
		end else begin
			convert_strobe_age_q <= 11'h000;
		end
	end

	sequence s_rise_held;
		rise ##1 strobe_lvl [*8];
	endsequence

	sequence s_wake;
		fall && q.phase != adc_pkg::ST_TRACK;
	endsequence

	sequence s_sleep_wake;
		fall && q.phase == adc_pkg::ST_SLEEP;
	endsequence

	sequence s_abort;
		fall && q.phase == adc_pkg::ST_CONVERT && !fifo_out_valid;
	endsequence

	a_rise_starts_convert_strobe: assert property (@(posedge mclk) // R01
		disable iff (!reset_n)
		rise && q.phase == adc_pkg::ST_TRACK |=>
		q.phase == adc_pkg::ST_CONVERT && q.hold && !q.drive_en)
		else $error("strobe rise did not start a held conversion");

	a_store_then_sleep: assert property (@(posedge mclk) // R02
		disable iff (!reset_n)
		q.phase == adc_pkg::ST_STORE && fifo_in_ready && !fall |=>
		q.phase == adc_pkg::ST_SLEEP && !q.bias_on)
		else $error("finished conversion did not enter sleep");

	a_wake_drives_out: assert property (@(posedge mclk) // R03
		disable iff (!reset_n)
		s_wake |=> q.drive_en && q.word == $past(wake_word))
		else $error("strobe fall did not drive the stored word");

	a_sleep_holds: assert property (@(posedge mclk) // R06
		disable iff (!reset_n)
		q.phase == adc_pkg::ST_SLEEP |-> q.hold && !q.bias_on)
		else $error("sample released or bias on during sleep");

	a_wake_tracks: assert property (@(posedge mclk) // R07
		disable iff (!reset_n)
		s_wake |=> !q.hold && q.bias_on && q.phase == adc_pkg::ST_TRACK)
		else $error("strobe fall did not resume tracking");

	a_convert_strobe_duration: assert property (@(posedge mclk) // R09
		disable iff (!reset_n)
		s_rise_held |-> ##[CONVERT_STROBE_LAG:CONVERT_STROBE_LAG] q.phase == adc_pkg::ST_STORE
		|| !strobe_lvl)
		else $error("conversion length differs from twelve steps");

	a_convert_strobe_in_time: assert property (@(posedge mclk) // R10
		disable iff (!reset_n)
		q.phase == adc_pkg::ST_CONVERT |-> convert_strobe_age_q < 11'(CONVERT_STROBE_LIMIT))
		else $error("conversion overran the grade conversion time");

	a_float_while_high: assert property (@(posedge mclk) // R12
		disable iff (!reset_n)
		strobe_lvl && q.strobe_q |-> !q.drive_en)
		else $error("data pin driven while strobe high");

	// a wake from sleep must show exactly the word this conversion made
	a_word_is_result: assert property (@(posedge mclk) // R03
		disable iff (!reset_n)
		s_sleep_wake |=> q.word == $past(q.trial))
		else $error("wake did not present the finished result");

	// an abandoned conversion must leave the older word on the wire
	a_abort_keeps: assert property (@(posedge mclk) // R03
		disable iff (!reset_n)
		s_abort |=> q.word == $past(q.word) && q.phase == adc_pkg::ST_TRACK)
		else $error("abandoned conversion disturbed the word");

	// every conversion opens with only the top trial bit set
	a_first_trial: assert property (@(posedge mclk) // R09
		disable iff (!reset_n)
		rise && q.phase == adc_pkg::ST_TRACK |=>
		q.trial == `MSB_TRIAL && q.bit_idx == 4'hB)
		else $error("conversion did not start from the top trial");

	// the step timer never holds more than one step of cycles
	a_step_bounded: assert property (@(posedge mclk) // R09
		disable iff (!reset_n)
		q.phase == adc_pkg::ST_CONVERT |-> q.timer <= STEP_LOAD)
		else $error("step timer above one step");

	// tracking means powered and sampling, never holding
	a_track_powered: assert property (@(posedge mclk) // R07
		disable iff (!reset_n)
		q.phase == adc_pkg::ST_TRACK |-> q.bias_on && !q.hold)
		else $error("tracking without power or with the sample held");

	// only the awake, tracking part may drive the data pin
	a_float_not_track: assert property (@(posedge mclk) // R12
		disable iff (!reset_n)
		q.phase != adc_pkg::ST_TRACK |-> !q.drive_en)
		else $error("data pin driven outside tracking");

	// checks, link domain
	a_shift_advances: assert property (@(negedge shift_clk) // R04
		disable iff (convert_strobe)
		lq.shifted != `LINK_SAT |=> lq.shifted == $past(lq.shifted) + 4'h1)
		else $error("shift clock did not advance the bit");

	a_zero_tail: assert property (@(negedge shift_clk) // R05
		disable iff (convert_strobe)
		lq.shifted == `LINK_SAT |-> !serial_result_out)
		else $error("nonzero bit after the twelve result bits");

endmodule // serial_adc_readout

// [core/adc_defines.svh]
// Purpose: shared constants of the serial converter readout block
// Assumes: core clock mclk at 100 MHz; conversion timed on mclk
// Notes: all timing counts derive from printed times and the clock rate
//
// Contract
// R01 - strobe rising edge starts a conversion and floats the serial output
// R02 - conversion ending with strobe high enters sleep, bias currents off
// R03 - strobe falling edge drives the output and presents result_msb first
// R04 - output advances on falling shift clock; host samples on rising edge
// R05 - after twelve bits, further shift clocks give zeros while strobe low
// R06 - sample-and-hold stays in hold during sleep until strobe goes low
// R07 - after strobe falls, power up and return sample-and-hold to tracking
// R08 - host keeps strobe low for acquisition_interval before next rise
// R09 - twelve-step conversion timed by internal oscillator, not shift clock
// R10 - grades support 100, 250 and 500 ksps sample rates
// R11 - host holds strobe high at least 8, 3 or 1.5 us per grade
// R12 - serial output floats for the whole time the strobe is high; code floats it from the synchronised rise
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

`define RESULT_BITS 12
`define FIFO_DEPTH 16
`define CLK_MHZ 100
`define LINK_SAT 4'hC
`define MSB_TRIAL 12'h800

// conversion time per grade, nanoseconds
`define TCONV_G0_NS 8000
`define TCONV_G1_NS 3000
`define TCONV_G2_NS 1500

// sample rates per grade, ksps
`define RATE_G0_KSPS 100
`define RATE_G1_KSPS 250
`define RATE_G2_KSPS 500

// longest time: whole conversion must fit, so each step rounds down
`define CONVERT_STROBE_CYCLES(ns) (((ns) * `CLK_MHZ) / 1000)
`define STEP_CYCLES(ns) (`CONVERT_STROBE_CYCLES(ns) / `RESULT_BITS)

`define SPEED_GRADE_DEF 2

`endif

// [core/adc_pkg.sv]
// Purpose: types of the serial converter readout block
// Assumes: used by name only, never imported
// Notes: one packed struct per clock domain holds the sequencer and link state; pin_sync and result_fifo keep their own
package adc_pkg;

	typedef enum logic [1:0] {
		ST_TRACK,
		ST_CONVERT,
		ST_STORE,
		ST_SLEEP
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic strobe_q;
		logic [6:0] timer;
		logic [3:0] bit_idx;
		logic [11:0] trial;
		logic [11:0] word;
		logic drive_en;
		logic hold;
		logic bias_on;
		logic push;
		logic busy;
	} core_state_t;

	typedef struct packed {
		logic [3:0] shifted;
	} link_state_t;

endpackage

// [core/pin_sync.sv]
// Purpose: three-flop synchroniser for a pin entering the mclk domain
// Assumes: pin_in is asynchronous to clk
// Notes: level moves only when the second and third stages agree
`timescale 1ns/10ps
module pin_sync (
	input wire logic clk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic pin_in, // raw pin level
	output logic level // filtered level
);
	logic [2:0] sh_q;
	logic level_q;

	// first stage feeds only the second; the filter looks at stages two and three
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sh_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			sh_q <= {sh_q[1:0], pin_in};
			if (sh_q[2] == sh_q[1]) begin
				level_q <= sh_q[2];
			end
		end
	end

	assign level = level_q;
endmodule // pin_sync

// [core/result_fifo.sv]
// Purpose: result buffer between converter and serial readout
// Assumes: single clock, DEPTH a power of two
// Notes: honest full and empty via an extra pointer bit
`timescale 1ns/10ps
module result_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // word in
	output logic out_valid, // word available
	input wire logic out_ready, // word taken
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;

	// same index with wrap bits differing means every slot is used
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// each slot loads only when the write pointer names it
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk) begin
			if (in_valid && !full && wr_q[AW-1:0] == AW'(i)) begin
				mem_q[i] <= in_data;
			end
		end
	end

	// pointers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule // result_fifo

// [tb/host_model.sv]
// Purpose: host side of the three-wire readout: strobe, shift clock, capture
// Assumes: strobe changes just after a falling mclk edge
// Notes: the shift clock stands low outside frames; 12 ns period
`timescale 1ns/10ps
module host_model (
	input wire logic mclk, // core clock, paces the strobe
	output logic convert_strobe, // strobe to the device
	output logic shift_clk, // link clock, idle low between frames
	input wire logic sdo_wire // resolved serial data pin
);
	initial begin
		convert_strobe = 1'b0;
		shift_clk = 1'b0;
	end

	// the caller keeps the high and low spans long enough
	task automatic set_strobe(input logic level);
		@(negedge mclk);
		convert_strobe = level;
	endtask

	// bare clock pulses, used to show that clocks outside a frame do nothing
	task automatic pulses(input int n);
		repeat (n) begin
			#6 shift_clk = 1'b1;
			#6 shift_clk = 1'b0;
		end
	endtask

	// capture on the rising edge; the device moves on at the falling one
	task automatic read_bits(input int n, output logic [15:0] bits);
		bits = 16'h0000;
		for (int i = 0; i < n; i++) begin
			#6 shift_clk = 1'b1;
			bits = {bits[14:0], sdo_wire};
			#6 shift_clk = 1'b0;
		end
	endtask
endmodule // host_model

// [tb/test_serial_adc_readout.sv]
// Purpose: self-checking bench of the conversion and serial readout block
// Assumes: fastest grade, so a conversion fits in 1.5 us of strobe high
// Notes: the comparator is ideal, so each result equals the analog code
`timescale 1ns/10ps
module test_serial_adc_readout;
	logic mclk, reset_n, serial_result_out, serial_result_oe;
	logic track_hold, bias_on, convert_strobe_busy;
	logic [11:0] dac_trial;
	logic [11:0] analog_code; // input level in codes
	wire logic convert_strobe, shift_clk, cmp_above, sdo_wire;
	int fails, checks_done;

	// ideal comparator and the three-state pin as the host sees it
	assign cmp_above = (analog_code >= dac_trial);
	assign sdo_wire = serial_result_oe ? serial_result_out : 1'bz;

	serial_adc_readout #(.SPEED_GRADE(2)) DUT (
		.mclk(mclk), // core clock
		.reset_n(reset_n), // reset
		.convert_strobe(convert_strobe), // from host
		.shift_clk(shift_clk), // from host
		.cmp_above(cmp_above), // comparator
		.serial_result_out(serial_result_out), // data
		.serial_result_oe(serial_result_oe), // pin drive
		.track_hold(track_hold), // sample-and-hold
		.bias_on(bias_on), // power
		.dac_trial(dac_trial), // trial code
		.convert_strobe_busy(convert_strobe_busy) // converting
	);

	host_model host (
		.mclk(mclk), // strobe pacing
		.convert_strobe(convert_strobe), // strobe
		.shift_clk(shift_clk), // link clock
		.sdo_wire(sdo_wire) // data pin
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one conversion then a 16-clock frame; junk clocks hit the conversion
	task automatic convert_strobe_and_read(input logic [11:0] code, input int junk);
		logic [15:0] bits;
		analog_code = code;
		host.set_strobe(1'b1);
		repeat (10) @(negedge mclk);
		check(16'(convert_strobe_busy), 16'h1, "busy after rise");
		check(16'(serial_result_oe), 16'h0, "pin floats converting");
		check(16'(dac_trial), 16'h0800, "first trial");
		host.pulses(junk); // ignored while the strobe is high
		repeat (150) @(negedge mclk);
		check(16'({convert_strobe_busy, bias_on, track_hold}), 16'h1, "sleep");
		check(16'(serial_result_oe), 16'h0, "pin floats asleep");
		check(16'(dac_trial), 16'(code), "result in trial");
		host.set_strobe(1'b0);
		#63;
		check(16'({serial_result_oe, track_hold, bias_on}), 16'h5, "wake");
		check(16'(sdo_wire), 16'(code[11]), "msb before clocks");
		host.read_bits(16, bits);
		check(bits, {code, 4'h0}, "frame then zeros");
		repeat (50) @(negedge mclk);
	endtask

	// strobe dropped mid-conversion: nothing is stored, the older word reads;
	// the long tail lets the abandoned conversion's window close first
	task automatic abort_and_read(input logic [11:0] prev);
		logic [15:0] bits;
		analog_code = ~prev;
		host.set_strobe(1'b1);
		repeat (40) @(negedge mclk);
		check(16'(convert_strobe_busy), 16'h1, "busy before abort");
		host.set_strobe(1'b0);
		#63;
		check(16'({convert_strobe_busy, track_hold, bias_on}), 16'h1, "abort wakes");
		check(16'(sdo_wire), 16'(prev[11]), "older msb");
		host.read_bits(16, bits);
		check(bits, {prev, 4'h0}, "older word kept");
		repeat (150) @(negedge mclk);
	endtask

	initial begin
		fails = 0;
		checks_done = 0;
		reset_n = 1'b0;
		analog_code = 12'h000;
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(negedge mclk);
		check(16'({bias_on, convert_strobe_busy}), 16'h2, "idle after reset");
		convert_strobe_and_read(12'hA5C, 0);
		convert_strobe_and_read(12'hFFF, 4);
		convert_strobe_and_read(12'h000, 0);
		convert_strobe_and_read(12'h5A3, 0);
		abort_and_read(12'h5A3);
		convert_strobe_and_read(12'h801, 0);
		final_report();
	end

	// six frames take about 14 us; allow far more before giving up
	initial begin
		#50000;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end
endmodule // test_serial_adc_readout
